// ### hw/ierr_consts.vh
`ifndef IERR_CONSTS_VH
`define IERR_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IERR_CTRL_OFS 12'h480
`define IERR_STAT_OFS 12'h484
`define IERR_MASK_OFS 12'h488
`define IERR_IRQ_STAT_OFS 12'h490
`define IERR_IRQ_CLR_OFS 12'h494
`define IERR_IRQ_EN_OFS 12'h498

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define IERR_EN_BIT 0
`define IERR_NUM_SRC 19
`define IERR_VALID_MASK 19'h7fff7
`define IERR_IRQ_REP_BIT 0
`define IERR_IRQ_ERR_BIT 1
`define IERR_NUM_IRQ 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IERR_CTRL_RST 1'h1
`define IERR_STAT_RST 19'h00000
`define IERR_MASK_RST 19'h00000
`define IERR_IRQ_EN_RST 2'h0

`endif

// ### hw/ierr_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "ierr_consts.vh"

module ierr_regs (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Avalon-MM slave
  input wire [11:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output reg [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Error sources, one-cycle or level events on clk_i
  input wire ingress_posted_timeout_i,
  input wire ingress_nonposted_timeout_i,
  input wire ingress_completion_timeout_i,
  input wire egress_posted_timeout_i,
  input wire egress_nonposted_timeout_i,
  input wire egress_completion_timeout_i,
  input wire ingress_data_ram_single_err_i,
  input wire ingress_data_ram_double_err_i,
  input wire ingress_ctrl_ram_single_err_i,
  input wire ingress_ctrl_ram_double_err_i,
  input wire egress_data_ram_single_err_i,
  input wire egress_data_ram_double_err_i,
  input wire egress_ctrl_ram_single_err_i,
  input wire egress_ctrl_ram_double_err_i,
  input wire datapath_parity_err_i,
  input wire unreliable_link_flag_i,
  input wire replay_ctrl_ram_single_err_i,
  input wire replay_ctrl_ram_double_err_i,
  // Toward advanced error reporting
  output reg internal_err_event_o,
  output wire internal_err_pending_o,
  // Interrupt
  output wire irq_o
);

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle on reads so read data comes from a flop.
  reg rd_done_q;
  wire rd_acc;
  wire wr_acc;

  assign rd_acc = avs_read_i & rd_done_q;
  assign wr_acc = avs_write_i;
  assign avs_waitrequest_o = avs_read_i & ~rd_done_q;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= avs_read_i & ~rd_done_q;
    end
  end

  wire sel_ctrl = (avs_address_i == `IERR_CTRL_OFS);
  wire sel_stat = (avs_address_i == `IERR_STAT_OFS);
  wire sel_mask = (avs_address_i == `IERR_MASK_OFS);
  wire sel_irqs = (avs_address_i == `IERR_IRQ_STAT_OFS);
  wire sel_irqc = (avs_address_i == `IERR_IRQ_CLR_OFS);
  wire sel_irqe = (avs_address_i == `IERR_IRQ_EN_OFS);

  // Byte-lane merge of write data
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wdata_be = avs_writedata_i & be_mask;

  // ----------------------------------------------------------------
  // Event vector
  // ----------------------------------------------------------------
  // Link flag is a level; only its rising edge counts as an event.
  reg link_flag_q;
  wire link_rise = unreliable_link_flag_i & ~link_flag_q;

  wire [`IERR_NUM_SRC-1:0] evt;
  assign evt = {replay_ctrl_ram_double_err_i, replay_ctrl_ram_single_err_i,
                link_rise,
                datapath_parity_err_i,
                egress_ctrl_ram_double_err_i, egress_ctrl_ram_single_err_i,
                egress_data_ram_double_err_i, egress_data_ram_single_err_i,
                ingress_ctrl_ram_double_err_i, ingress_ctrl_ram_single_err_i,
                ingress_data_ram_double_err_i, ingress_data_ram_single_err_i,
                egress_completion_timeout_i, egress_nonposted_timeout_i,
                egress_posted_timeout_i,
                1'b0,
                ingress_completion_timeout_i, ingress_nonposted_timeout_i,
                ingress_posted_timeout_i};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg ctrl_en_q;
  reg [`IERR_NUM_SRC-1:0] stat_q;
  reg [`IERR_NUM_SRC-1:0] mask_q;
  reg [`IERR_NUM_IRQ-1:0] irq_stat_q;
  reg [`IERR_NUM_IRQ-1:0] irq_en_q;

  wire [`IERR_NUM_SRC-1:0] stat_clr = (wr_acc & sel_stat) ?
    wdata_be[`IERR_NUM_SRC-1:0] : {`IERR_NUM_SRC{1'b0}};
  wire [`IERR_NUM_SRC-1:0] new_set = evt & ~stat_q;
  wire [`IERR_NUM_SRC-1:0] stat_d;

  // Reserved positions never hold a one
  localparam [`IERR_NUM_SRC-1:0] VALID_BITS = `IERR_VALID_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < `IERR_NUM_SRC; gi = gi + 1) begin : g_stat
      if (VALID_BITS[gi]) begin : g_live
        // Set wins over a same-cycle clear, so no event is ever lost
        assign stat_d[gi] = evt[gi] | (stat_q[gi] & ~stat_clr[gi]);
      end else begin : g_resv
        assign stat_d[gi] = 1'b0;
      end
    end
  endgenerate

  // Reporting path: masked bits do not report, status untouched
  wire [`IERR_NUM_SRC-1:0] unmasked = stat_q & ~mask_q;

  // ----------------------------------------------------------------
  // Per-source report qualification
  // ----------------------------------------------------------------
  // Only a fresh set reports; a bit already latched stays quiet.
  wire [`IERR_NUM_SRC-1:0] report_bits;

  genvar gj;
  generate
    for (gj = 0; gj < `IERR_NUM_SRC; gj = gj + 1) begin : g_rep
      if (VALID_BITS[gj]) begin : g_live
        assign report_bits[gj] = new_set[gj] & ~mask_q[gj];
      end else begin : g_resv
        assign report_bits[gj] = 1'b0;
      end
    end
  endgenerate

  wire report_event = ctrl_en_q & (|report_bits);
  assign internal_err_pending_o = ctrl_en_q & |unmasked;

  wire [`IERR_NUM_IRQ-1:0] irq_evt = {|new_set, report_event};
  wire [`IERR_NUM_IRQ-1:0] irq_clr = (wr_acc & sel_irqc) ?
    wdata_be[`IERR_NUM_IRQ-1:0] : {`IERR_NUM_IRQ{1'b0}};

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  wire ctrl_wr = wr_acc & sel_ctrl & avs_byteenable_i[0];

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_en_q <= `IERR_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_en_q <= avs_writedata_i[`IERR_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_q <= `IERR_STAT_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ----------------------------------------------------------------
  // Link flag edge detector
  // ----------------------------------------------------------------
  // Reset low: a flag already high after reset still reports once.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_flag_q <= 1'b0;
    end else begin
      link_flag_q <= unreliable_link_flag_i;
    end
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  wire mask_wr = wr_acc & sel_mask;
  wire [`IERR_NUM_SRC-1:0] mask_keep = mask_q & ~be_mask[`IERR_NUM_SRC-1:0];
  wire [`IERR_NUM_SRC-1:0] mask_new = wdata_be[`IERR_NUM_SRC-1:0] & VALID_BITS;
  wire [`IERR_NUM_SRC-1:0] mask_d = mask_keep | mask_new;

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= `IERR_MASK_RST;
    end else if (mask_wr) begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // Error event output
  // ----------------------------------------------------------------
  // Registered so the reporting side sees a clean one-cycle pulse.
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      internal_err_event_o <= 1'b0;
    end else begin
      internal_err_event_o <= report_event;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt registers
  // ----------------------------------------------------------------
  wire irqe_wr = wr_acc & sel_irqe & avs_byteenable_i[0];
  wire [`IERR_NUM_IRQ-1:0] irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_stat_q <= {`IERR_NUM_IRQ{1'b0}};
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_en_q <= `IERR_IRQ_EN_RST;
    end else if (irqe_wr) begin
      irq_en_q <= avs_writedata_i[`IERR_NUM_IRQ-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Unmapped and write-only addresses read zero.
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_word[`IERR_EN_BIT] = ctrl_en_q;
    end else if (sel_stat) begin
      rd_word[`IERR_NUM_SRC-1:0] = stat_q;
    end else if (sel_mask) begin
      rd_word[`IERR_NUM_SRC-1:0] = mask_q;
    end else if (sel_irqs) begin
      rd_word[`IERR_NUM_IRQ-1:0] = irq_stat_q;
    end else if (sel_irqe) begin
      rd_word[`IERR_NUM_IRQ-1:0] = irq_en_q;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // Captured in the wait cycle, so data stands when waitrequest drops
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i & ~rd_done_q) begin
      avs_readdata_o <= rd_word;
    end
  end

  wire unused_ok = rd_acc;

endmodule
`default_nettype wire

// ### testbench/ierr_props.sv
`timescale 1ns/1ps
`default_nettype none
module ierr_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Register bus
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Reporting
  input wire logic internal_err_event_o,
  input wire logic internal_err_pending_o,
  input wire logic irq_o
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_WR_NOWAIT: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  AST_RD_WAIT: assert property ($rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read wait wrong");
  AST_RD_RESV: assert property (avs_readdata_o[31:19] == 13'h0 && !avs_readdata_o[3])
    else $error("reserved bits set");
  AST_UNMAPPED: assert property (avs_read_i && !avs_waitrequest_o && !(avs_address_i inside
    {12'h480, 12'h484, 12'h488, 12'h490, 12'h494, 12'h498}) |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_STABLE: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved");
  AST_EV_CAUSE: assert property ($rose(internal_err_pending_o) && !$past(avs_write_i) |-> ##[0:1] internal_err_event_o)
    else $error("no event on new error");
  AST_EN_GATE: assert property (!internal_err_pending_o && !$past(internal_err_pending_o) |-> !internal_err_event_o)
    else $error("event while gated");
  AST_PEND_FALL: assert property ($fell(internal_err_pending_o) |-> $past(avs_write_i))
    else $error("pending fell alone");
  COV_EVENT: cover property (internal_err_event_o);
  COV_IRQ: cover property ($rose(irq_o));
  COV_READ: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind ierr_regs ierr_props u_ierr_props (.*);
`default_nettype wire

// ### testbench/tb_internal_error_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ierr_consts.vh"
module tb_internal_error_status_regs;
  localparam logic [11:0] ST = `IERR_STAT_OFS;
  localparam logic [11:0] MK = `IERR_MASK_OFS;
  localparam logic [11:0] CT = `IERR_CTRL_OFS;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, rd = 1'b0, we = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [31:0] wd = 32'h0, q, es = 32'h0, lf = 32'hb035;
  logic [18:0] ev = 19'h0;
  wire [31:0] rdata;
  wire wreq, evo, pend, irq;
  int fails = 0, total_checks = 0, evn = 0, n, e0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (evo === 1'b1) evn <= evn + 1;
  ierr_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(we), .avs_byteenable_i(4'hf), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .ingress_posted_timeout_i(ev[0]),
    .ingress_nonposted_timeout_i(ev[1]), .ingress_completion_timeout_i(ev[2]),
    .egress_posted_timeout_i(ev[4]), .egress_nonposted_timeout_i(ev[5]),
    .egress_completion_timeout_i(ev[6]), .ingress_data_ram_single_err_i(ev[7]),
    .ingress_data_ram_double_err_i(ev[8]), .ingress_ctrl_ram_single_err_i(ev[9]),
    .ingress_ctrl_ram_double_err_i(ev[10]), .egress_data_ram_single_err_i(ev[11]),
    .egress_data_ram_double_err_i(ev[12]), .egress_ctrl_ram_single_err_i(ev[13]),
    .egress_ctrl_ram_double_err_i(ev[14]), .datapath_parity_err_i(ev[15]),
    .unreliable_link_flag_i(ev[16]), .replay_ctrl_ram_single_err_i(ev[17]),
    .replay_ctrl_ram_double_err_i(ev[18]), .internal_err_event_o(evo),
    .internal_err_pending_o(pend), .irq_o(irq));
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is seen low at an edge
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !w;
    we <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      fails++;
      summarize();
    end
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // One-cycle event pulse; the flag input rises from low too
  task fire(input logic [18:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 19'h0;
    es = es | {13'h0, v & `IERR_VALID_MASK};
  endtask
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (5) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rchk(CT, 32'h1);
    rchk(ST, 32'h0);
    rchk(MK, 32'h0);
    e0 = evn;
    for (int k = 0; k < 19; k++) begin
      fire(19'h1 << k);
      rchk(ST, es);
      bus(1'b1, ST, es);
      es = 32'h0;
    end
    chk(evn - e0, 18);
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      fire(lf[18:0]);
      lf = nxt(lf);
      bus(1'b1, ST, lf);
      es = es & ~lf;
      rchk(ST, es);
    end
    bus(1'b1, ST, 32'hffffffff);
    es = 32'h0;
    bus(1'b1, MK, 32'hffffffff);
    rchk(MK, {13'h0, `IERR_VALID_MASK});
    bus(1'b1, `IERR_IRQ_CLR_OFS, 32'h3);
    bus(1'b1, `IERR_IRQ_EN_OFS, 32'h1);
    e0 = evn;
    fire(19'h8020);
    rchk(ST, es);
    chk({pend, irq, 30'h0}, 32'h0);
    chk(evn - e0, 0);
    rchk(`IERR_IRQ_STAT_OFS, 32'h2);
    bus(1'b1, CT, 32'h0);
    bus(1'b1, MK, 32'h0);
    rchk(CT, 32'h0);
    chk(pend, 0);
    e0 = evn;
    fire(19'h1);
    rchk(ST, es);
    chk(evn - e0, 0);
    bus(1'b1, CT, 32'h1);
    #1;
    chk(pend, 1);
    bus(1'b1, `IERR_IRQ_CLR_OFS, 32'h3);
    bus(1'b1, `IERR_IRQ_EN_OFS, 32'h2);
    fire(19'h40);
    #1;
    chk(irq, 1);
    bus(1'b1, `IERR_IRQ_CLR_OFS, 32'h3);
    #1;
    chk(irq, 0);
    bus(1'b1, 12'h4a0, 32'hffffffff);
    rchk(12'h4a0, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
